//--- rtl/scc_clock_ctrl.v
`timescale 1ns/1ps
`include "scc_defs.vh"

// Operation
// - stop release waits selected time only if main crystal ran the cpu.
// - reset loads wait select register with 05h.
// - codes 1..5 select 2^11,2^13,2^14,2^15,2^16 crystal cycles.
// - counter stops at selected wait; status never goes beyond it.
// - counting starts when oscillation begins, not at stop release.
// - on-chip oscillator starts once reset is released; its stop bit halts it when the cpu runs on main crystal or subsystem.
// - prescaler divides the clock that currently feeds the cpu.
// - reset clears cpu clock select so on-chip oscillator runs cpu.
// - cpu clock gated for 17 on-chip cycles after reset release.
// - both oscillators stopped while reset is asserted.
// - read-only bit 1 of main clock mode shows clock in use.
// - on subsystem clock, crystal via pcc; halt allowed, stop refused.
// - status bit reads 0 on on-chip oscillator, 1 on main crystal.
// - counter status bits set in order from shortest, stay set.
module scc_clock_ctrl #(
   parameter ONCHIP_STOPPABLE = 1
) (
   clk,
   rst_b,
   sfr_addr,
   sfr_wr,
   sfr_wdata,
   sfr_rd,
   sfr_rdata_ff,
   stop_req,
   wake_req,
   osc_started,
   xtal_tick,
   onchip_tick,
   cpu_clk_en_ff,
   main_osc_run_ff,
   onchip_osc_run_ff,
   presc_main_sel_ff,
   cpu_on_subsys_ff,
   in_stop_ff,
   feedback_dis_ff
);
   input  wire          clk;
   input  wire          rst_b;
   input  wire [15:0]   sfr_addr;
   input  wire          sfr_wr;
   input  wire [7:0]    sfr_wdata;
   input  wire          sfr_rd;
   output reg  [7:0]    sfr_rdata_ff;
   input  wire          stop_req;
   input  wire          wake_req;
   input  wire          osc_started;
   input  wire          xtal_tick;
   input  wire          onchip_tick;
   output reg           cpu_clk_en_ff;
   output reg           main_osc_run_ff;
   output reg           onchip_osc_run_ff;
   output reg           presc_main_sel_ff;
   output reg           cpu_on_subsys_ff;
   output reg           in_stop_ff;
   output reg           feedback_dis_ff;

   reg  [2:0]    wait_sel_ff;
   reg           onchip_stop_ff;
   reg           cpu_sel_ff;
   reg           cpu_status_ff;
   reg           main_stop_ff;
   reg  [7:0]    pcc_ff;
   reg  [4:0]    holdoff_ff;
   reg           stop_on_main_ff;
   reg           waking_ff;
   wire [4:0]    stab_status;
   wire          limit_done;
   wire          holdoff_done;
   wire          subsys;
   wire          stop_ok;
   wire          cnt_clr;
   wire          wr_hit_moc;
   wire          wr_hit_pcc;

   ////////////////////////////////////////////////////////////////////////
   // register writes and clock state
   assign subsys       = pcc_ff[`SCC_BIT_SUBSYS_SEL];
   assign stop_ok      = stop_req && !subsys && !in_stop_ff;
   assign holdoff_done = (holdoff_ff == `SCC_HOLDOFF_CYCLES);
   assign wr_hit_moc   = sfr_wr && (sfr_addr == `SCC_ADDR_MAIN_OSC_CONTROL);
   assign wr_hit_pcc   = sfr_wr && (sfr_addr == `SCC_ADDR_PROC_CLOCK_CTRL);
   assign cnt_clr      = stop_ok
                       || (wr_hit_moc && sfr_wdata[`SCC_BIT_MAIN_STOP] && !main_stop_ff)
                       || (wr_hit_pcc && sfr_wdata[`SCC_BIT_PCC_MAIN_STOP] && !pcc_ff[7]);

   always @(posedge clk) begin
      if (!rst_b) begin
         wait_sel_ff     <= `SCC_RST_WAIT_FIELD;
         onchip_stop_ff  <= 1'b0;
         cpu_sel_ff      <= 1'b0;
         cpu_status_ff   <= 1'b0;
         main_stop_ff    <= 1'b0;
         pcc_ff          <= `SCC_RST_ZERO;
         holdoff_ff      <= 5'h00;
         stop_on_main_ff <= 1'b0;
         waking_ff       <= 1'b0;
         in_stop_ff      <= 1'b0;
      end else begin
         if (sfr_wr) begin
            case (sfr_addr)
               `SCC_ADDR_WAIT_SELECT:     wait_sel_ff    <= sfr_wdata[2:0];
               `SCC_ADDR_ONCHIP_OSC_MODE: onchip_stop_ff <= sfr_wdata[`SCC_BIT_ONCHIP_STOP];
               `SCC_ADDR_MAIN_CLOCK_MODE: cpu_sel_ff     <= sfr_wdata[`SCC_BIT_CPU_CLK_SEL];
               `SCC_ADDR_MAIN_OSC_CONTROL: main_stop_ff  <= sfr_wdata[`SCC_BIT_MAIN_STOP];
               `SCC_ADDR_PROC_CLOCK_CTRL: pcc_ff         <= sfr_wdata & 8'hd0;
               default: ;
            endcase
         end
         // status follows the selection one cycle later, gated or not
         cpu_status_ff <= cpu_sel_ff;
         if (!holdoff_done && onchip_tick) begin
            holdoff_ff <= holdoff_ff + 5'h01;
         end
         if (stop_ok) begin
            in_stop_ff      <= 1'b1;
            stop_on_main_ff <= cpu_status_ff;
         end else if (in_stop_ff && wake_req) begin
            in_stop_ff <= 1'b0;
            waking_ff  <= stop_on_main_ff;
         end else if (waking_ff && limit_done) begin
            waking_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stabilization counter
   scc_stab_counter #(
      .CW (17)
   ) u_stab (
      .clk        (clk),
      .rst_b      (rst_b),
      .clr        (cnt_clr),
      .count_en   (main_osc_run_ff && osc_started),
      .xtal_tick  (xtal_tick),
      .wait_sel   (wait_sel_ff),
      .status     (stab_status),
      .limit_done (limit_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // outputs
   always @(posedge clk) begin
      if (!rst_b) begin
         cpu_clk_en_ff     <= 1'b0;
         main_osc_run_ff   <= 1'b0;
         onchip_osc_run_ff <= 1'b0;
         presc_main_sel_ff <= 1'b0;
         cpu_on_subsys_ff  <= 1'b0;
         feedback_dis_ff   <= 1'b0;
         sfr_rdata_ff      <= 8'h00;
      end else begin
         cpu_clk_en_ff     <= holdoff_done && !in_stop_ff && !(waking_ff && !limit_done);
         main_osc_run_ff   <= !in_stop_ff
                              && !(main_stop_ff && !cpu_status_ff && !subsys)
                              && !(pcc_ff[`SCC_BIT_PCC_MAIN_STOP] && subsys);
         onchip_osc_run_ff <= !((ONCHIP_STOPPABLE != 0) && onchip_stop_ff
                                && (cpu_status_ff || subsys)) || !holdoff_done;
         presc_main_sel_ff <= cpu_status_ff;
         cpu_on_subsys_ff  <= subsys;
         feedback_dis_ff   <= pcc_ff[`SCC_BIT_FEEDBACK_DIS];
         if (sfr_rd) begin
            case (sfr_addr)
               `SCC_ADDR_WAIT_SELECT:      sfr_rdata_ff <= {5'h00, wait_sel_ff};
               `SCC_ADDR_ONCHIP_OSC_MODE:  sfr_rdata_ff <= {7'h00, onchip_stop_ff};
               `SCC_ADDR_MAIN_CLOCK_MODE:  sfr_rdata_ff <= {6'h00, cpu_status_ff, cpu_sel_ff};
               `SCC_ADDR_MAIN_OSC_CONTROL: sfr_rdata_ff <= {main_stop_ff, 7'h00};
               `SCC_ADDR_STAB_STATUS:      sfr_rdata_ff <= {3'h0, stab_status};
               `SCC_ADDR_PROC_CLOCK_CTRL:  sfr_rdata_ff <= pcc_ff;
               default:                    sfr_rdata_ff <= 8'h00;
            endcase
         end
      end
   end
endmodule

//--- rtl/scc_defs.vh
`ifndef SCC_DEFS_VH
`define SCC_DEFS_VH

// register addresses
`define SCC_ADDR_ONCHIP_OSC_MODE   16'hffa0
`define SCC_ADDR_MAIN_CLOCK_MODE   16'hffa1
`define SCC_ADDR_MAIN_OSC_CONTROL  16'hffa2
`define SCC_ADDR_STAB_STATUS       16'hffa3
`define SCC_ADDR_WAIT_SELECT       16'hffa4
`define SCC_ADDR_PROC_CLOCK_CTRL   16'hfffb

// reset values
`define SCC_RST_WAIT_SELECT        8'h05
`define SCC_RST_WAIT_FIELD         3'h5
`define SCC_RST_ZERO               8'h00

// field positions
`define SCC_BIT_ONCHIP_STOP        0
`define SCC_BIT_CPU_CLK_SEL        0
`define SCC_BIT_CPU_CLK_STATUS     1
`define SCC_BIT_MAIN_STOP          7
`define SCC_BIT_PCC_MAIN_STOP      7
`define SCC_BIT_FEEDBACK_DIS       6
`define SCC_BIT_SUBSYS_SEL         4

// wait select codes
`define SCC_WAIT_2E11              3'h1
`define SCC_WAIT_2E13              3'h2
`define SCC_WAIT_2E14              3'h3
`define SCC_WAIT_2E15              3'h4
`define SCC_WAIT_2E16              3'h5

// stabilization thresholds in main crystal cycles
`define SCC_CNT_2E11               17'h00800
`define SCC_CNT_2E13               17'h02000
`define SCC_CNT_2E14               17'h04000
`define SCC_CNT_2E15               17'h08000
`define SCC_CNT_2E16               17'h10000

// cpu clock hold-off after reset, on-chip oscillator cycles
`define SCC_HOLDOFF_CYCLES         5'h11

`endif

//--- rtl/scc_stab_counter.v
`timescale 1ns/1ps
`include "scc_defs.vh"

module scc_stab_counter #(
   parameter CW = 17
) (
   clk,
   rst_b,
   clr,
   count_en,
   xtal_tick,
   wait_sel,
   status,
   limit_done
);
   input  wire          clk;
   input  wire          rst_b;
   input  wire          clr;
   input  wire          count_en;
   input  wire          xtal_tick;
   input  wire [2:0]    wait_sel;
   output wire [4:0]    status;
   output wire          limit_done;

   reg  [CW-1:0] cnt_ff;
   reg  [CW-1:0] nxt_cnt;
   reg  [4:0]    status_ff;
   reg  [4:0]    nxt_status;
   reg  [CW-1:0] limit;

   ////////////////////////////////////////////////////////////////////////
   always @* begin
      case (wait_sel)
         `SCC_WAIT_2E11: limit = `SCC_CNT_2E11;
         `SCC_WAIT_2E13: limit = `SCC_CNT_2E13;
         `SCC_WAIT_2E14: limit = `SCC_CNT_2E14;
         `SCC_WAIT_2E15: limit = `SCC_CNT_2E15;
         default:        limit = `SCC_CNT_2E16;
      endcase
   end

   assign limit_done = (cnt_ff >= limit);

   always @* begin
      nxt_cnt    = cnt_ff;
      nxt_status = status_ff;
      if (clr) begin
         nxt_cnt    = {CW{1'b0}};
         nxt_status = 5'h00;
      end else begin
         // counts only once oscillation runs, never past the limit
         if (count_en && xtal_tick && !limit_done) begin
            nxt_cnt = cnt_ff + {{(CW-1){1'b0}}, 1'b1};
         end
         // sticky, shortest threshold first
         nxt_status = status_ff | {nxt_cnt >= `SCC_CNT_2E11, nxt_cnt >= `SCC_CNT_2E13,
                                   nxt_cnt >= `SCC_CNT_2E14, nxt_cnt >= `SCC_CNT_2E15,
                                   nxt_cnt >= `SCC_CNT_2E16};
      end
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         cnt_ff    <= {CW{1'b0}};
         status_ff <= 5'h00;
      end else begin
         cnt_ff    <= nxt_cnt;
         status_ff <= nxt_status;
      end
   end

   assign status = status_ff;
endmodule

//--- testbench/scc_clock_ctrl_checker.sv
`timescale 1ns/1ps
module scc_clock_ctrl_checker (
   input logic        clk,
   input logic        rst_b,
   input logic [15:0] sfr_addr,
   input logic        sfr_rd,
   input logic [7:0]  sfr_rdata_ff,
   input logic        stop_req,
   input logic        osc_started,
   input logic        onchip_tick,
   input logic        cpu_clk_en_ff,
   input logic        main_osc_run_ff,
   input logic        onchip_osc_run_ff,
   input logic        presc_main_sel_ff,
   input logic        cpu_on_subsys_ff,
   input logic        in_stop_ff
);
   logic [4:0] tick_cnt_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////
   // on-chip ticks seen since reset release, saturating
   always @(posedge clk) begin
      if (!rst_b)
         tick_cnt_ff <= 5'h00;
      else if (onchip_tick && tick_cnt_ff != 5'h1f)
         tick_cnt_ff <= tick_cnt_ff + 5'h01;
   end
   ////////////////////////////////////////////////////////////
   a_osc_rst_off: assert property (disable iff (1'b0) !rst_b |=> !main_osc_run_ff && !onchip_osc_run_ff)
      else $error("oscillator running in reset");
   a_onchip_runs: assert property ($rose(rst_b) |=> onchip_osc_run_ff)
      else $error("on-chip oscillator not started");
   a_cpu_holdoff: assert property (tick_cnt_ff < 5'h11 |-> !cpu_clk_en_ff)
      else $error("cpu clock before hold-off end");
   a_stat_order: assert property (sfr_rd && sfr_addr == 16'hffa3 |=>
      sfr_rdata_ff inside {8'h00, 8'h10, 8'h18, 8'h1c, 8'h1e, 8'h1f})
      else $error("status bits out of order");
   a_sel_upper_zero: assert property (sfr_rd && sfr_addr == 16'hffa4 |=> sfr_rdata_ff[7:3] == 5'h00)
      else $error("wait select upper bits set");
   a_subsys_no_stop: assert property (stop_req && cpu_on_subsys_ff && !in_stop_ff |=> !in_stop_ff)
      else $error("stop taken on subsystem clock");
   a_stop_gates: assert property (stop_req && !cpu_on_subsys_ff && !in_stop_ff |=>
      in_stop_ff ##1 (!cpu_clk_en_ff && !main_osc_run_ff))
      else $error("stop entry not gating");
   a_wait_no_osc: assert property (!osc_started && presc_main_sel_ff && !cpu_clk_en_ff |=> !cpu_clk_en_ff)
      else $error("cpu clock before oscillation");
   c_stop: cover property (stop_req && !in_stop_ff && !cpu_on_subsys_ff);
   c_main_wait: cover property (presc_main_sel_ff && !osc_started && !cpu_clk_en_ff);
   c_stat_read: cover property (sfr_rd && sfr_addr == 16'hffa3);
endmodule
bind scc_clock_ctrl scc_clock_ctrl_checker chk_u (.clk, .rst_b, .sfr_addr, .sfr_rd, .sfr_rdata_ff, .stop_req,
   .osc_started, .onchip_tick, .cpu_clk_en_ff, .main_osc_run_ff, .onchip_osc_run_ff, .presc_main_sel_ff,
   .cpu_on_subsys_ff, .in_stop_ff);

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic        clk, rst_b, sfr_wr, sfr_rd, stop_req, wake_req, osc_started, xtal_tick, onchip_tick;
   logic [15:0] sfr_addr;
   logic [7:0]  sfr_wdata, rd_val, d, en_mid;
   wire  [7:0]  sfr_rdata_ff;
   wire         cpu_clk_en_ff, main_osc_run_ff, onchip_osc_run_ff, presc_main_sel_ff;
   wire         cpu_on_subsys_ff, in_stop_ff, feedback_dis_ff;
   int          n_errors, checks_done, n;
   scc_clock_ctrl dut_u (.clk, .rst_b, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata_ff, .stop_req,
      .wake_req, .osc_started, .xtal_tick, .onchip_tick, .cpu_clk_en_ff, .main_osc_run_ff, .onchip_osc_run_ff,
      .presc_main_sel_ff, .cpu_on_subsys_ff, .in_stop_ff, .feedback_dis_ff);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(negedge clk) onchip_tick <= 1'($urandom);
   ////////////////////////////////////////////////////////////
   function automatic int wait_len(input logic [2:0] c);
      return 1 << ((c == 3'h1) ? 11 : 32'(c) + 11);
   endfunction
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
      @(negedge clk);
   endtask
   task automatic rd(input logic [15:0] a);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      rd_val = sfr_rdata_ff;
      @(negedge clk);
   endtask
   task automatic wait_en(input int lim, output int cnt);
      cnt = 0;
      while (cpu_clk_en_ff !== 1'b1 && cnt < lim) begin
         @(negedge clk);
         cnt++;
      end
      if (cnt >= lim) begin
         n_errors++;
         finish_test();
      end
   endtask
   // stop, oscillation held off 50 cycles after wake, then wait for cpu clock
   task automatic stop_wake(output int cnt);
      stop_req = 1'b1;
      @(negedge clk);
      stop_req = 1'b0;
      osc_started = 1'b0;
      repeat (2) @(negedge clk);
      chk("in_stop", 8'h01, {7'h00, in_stop_ff});
      wake_req = 1'b1;
      @(negedge clk);
      wake_req = 1'b0;
      repeat (50) @(negedge clk);
      en_mid = {7'h00, cpu_clk_en_ff};
      osc_started = 1'b1;
      wait_en(2200, cnt);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(63613));
      {n_errors, checks_done} = 0;
      {rst_b, sfr_wr, sfr_rd, stop_req, wake_req, osc_started} = 6'h00;
      {sfr_addr, sfr_wdata} = 24'h000000;
      xtal_tick = 1'b1;
      repeat (12) @(negedge clk);
      chk("main_osc_rst", 8'h00, {7'h00, main_osc_run_ff});
      rst_b = 1'b1;
      @(negedge clk);
      chk("onchip_run", 8'h01, {7'h00, onchip_osc_run_ff});
      chk("cpu_en_hold", 8'h00, {7'h00, cpu_clk_en_ff});
      rd(16'hffa4);
      chk("wait_sel_rst", 8'h05, rd_val);
      rd(16'hffa1);
      chk("clk_mode_rst", 8'h00, rd_val);
      wait_en(200, n);
      wr(16'hffa2, 8'h80);
      chk("main_stopped", 8'h00, {7'h00, main_osc_run_ff});
      wr(16'hffa2, 8'h00);
      chk("main_restart", 8'h01, {7'h00, main_osc_run_ff});
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         d[2:0] = 3'(i % 5 + 1);
         wr(16'hffa4, d);
         rd(16'hffa4);
         chk("wait_sel", {5'h00, d[2:0]}, rd_val);
      end
      rd(16'hff00);
      chk("unmapped", 8'h00, rd_val);
      wr(16'hffa4, 8'h01);
      stop_wake(n);
      chk("onchip_wake_en", 8'h01, en_mid);
      repeat (2100) @(negedge clk);
      rd(16'hffa3);
      chk("stab_status", 8'h10, rd_val);
      wr(16'hffa1, 8'h01);
      repeat (3) @(negedge clk);
      rd(16'hffa1);
      chk("clk_status", 8'h03, rd_val);
      chk("presc_src", 8'h01, {7'h00, presc_main_sel_ff});
      wr(16'hffa0, 8'h01);
      chk("onchip_stopped", 8'h00, {7'h00, onchip_osc_run_ff});
      wr(16'hffa0, 8'h00);
      stop_wake(n);
      chk("main_wake_hold", 8'h00, en_mid);
      chk("wait_len", 8'h01, {7'h00, n >= wait_len(3'h1) && n <= wait_len(3'h1) + 8});
      wr(16'hfffb, 8'h50);
      chk("subsys_flags", 8'h03, {6'h00, cpu_on_subsys_ff, feedback_dis_ff});
      stop_req = 1'b1;
      @(negedge clk);
      stop_req = 1'b0;
      repeat (2) @(negedge clk);
      chk("subsys_stop", 8'h00, {7'h00, in_stop_ff});
      wr(16'hfffb, 8'h00);
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      chk("osc_rst", 8'h00, {6'h00, main_osc_run_ff, onchip_osc_run_ff});
      rst_b = 1'b1;
      @(negedge clk);
      rd(16'hffa4);
      chk("wait_sel_rst2", 8'h05, rd_val);
      finish_test();
   end
endmodule
